/* File: hdl/frs_pkg.sv */
`default_nettype none

package frs_pkg;
    localparam int FRS_DW    = 36;
    localparam int FRS_BW    = 9;
    localparam int FRS_LANES = 4;
    localparam int FRS_PW    = 6;
    localparam int FRS_LW    = 7;
    localparam int FRS_LVW   = 6;

    localparam logic [FRS_LW-1:0] FRS_FULL_LVL = 7'h40;

    // register byte offsets
    localparam logic [11:0] FRS_OFF_LEVEL = 12'h000;
    localparam logic [11:0] FRS_OFF_STAT  = 12'h004;
    localparam logic [11:0] FRS_OFF_ISTAT = 12'h008;
    localparam logic [11:0] FRS_OFF_IMASK = 12'h00C;

    // field positions
    localparam int FRS_AE_POS  = 0;
    localparam int FRS_AF_POS  = 8;
    localparam int FRS_LVL_POS = 8;

    // reset values
    localparam logic [FRS_LVW-1:0] FRS_AE_RST = 6'h08;
    localparam logic [FRS_LVW-1:0] FRS_AF_RST = 6'h08;

    // interrupt bits
    localparam int FRS_IRQ_W     = 4;
    localparam int FRS_IRQ_EMPTY = 0;
    localparam int FRS_IRQ_FULL  = 1;
    localparam int FRS_IRQ_OVF   = 2;
    localparam int FRS_IRQ_UNF   = 3;

    // {width_sel_hi, width_sel_lo}
    typedef enum logic [1:0] {
        FRS_LONG = 2'h0,
        FRS_WORD = 2'h1,
        FRS_BYTE = 2'h2,
        FRS_MAIL = 2'h3
    } frs_width_type;
endpackage : frs_pkg

`default_nettype wire

/* File: hdl/frs_rd_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface frs_rd_if;
    import frs_pkg::*;
    logic              push;
    logic [FRS_DW-1:0] wdata;
    logic              fetch;
    logic [1:0]        rel_n;
    logic [FRS_DW-1:0] word;
    logic              avail;
    logic [FRS_LW-1:0] level_nx;

    modport store  (input push, wdata, fetch, rel_n,
                    output word, avail, level_nx);
    modport unpack (input fetch, word);
endinterface : frs_rd_if

`default_nettype wire

/* File: hdl/frs_store.sv */
`timescale 1ns/1ps
`default_nettype none

module frs_store import frs_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    frs_rd_if.store   rd
);
    logic [FRS_DW-1:0] mem [2**FRS_PW];
    logic [FRS_PW-1:0] wptr_q;
    logic [FRS_PW-1:0] rptr_q;
    logic [FRS_LW-1:0] unread_q;
    logic [FRS_LW-1:0] level_q;

    // level counts words until their last piece leaves
    assign rd.level_nx = level_q + FRS_LW'(rd.push) - FRS_LW'(rd.rel_n);
    assign rd.avail    = (unread_q != '0);
    assign rd.word     = mem[rptr_q];

    always_ff @(posedge pclk)
    begin
        if (rd.push)
            mem[wptr_q] <= rd.wdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wptr_q   <= '0;
            rptr_q   <= '0;
            unread_q <= '0;
            level_q  <= '0;
        end
        else
        begin
            wptr_q   <= wptr_q + FRS_PW'(rd.push);
            rptr_q   <= rptr_q + FRS_PW'(rd.fetch);
            unread_q <= unread_q + FRS_LW'(rd.push) - FRS_LW'(rd.fetch);
            level_q  <= rd.level_nx;
        end
    end
endmodule : frs_store

`default_nettype wire

/* File: hdl/frs_top.sv */
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module frs_top import frs_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              port_a_select_n,
    input  wire logic              port_a_direction,
    input  wire logic              port_a_mailbox_sel,
    input  wire logic [FRS_DW-1:0] port_a_data,
    input  wire logic              port_b_select_n,
    input  wire logic              port_b_direction,
    input  wire logic              port_b_mailbox_sel,
    input  wire logic              width_sel_lo,
    input  wire logic              width_sel_hi,
    input  wire logic              swap_sel_lo,
    input  wire logic              swap_sel_hi,
    input  wire logic              big_endian_select,
    output logic      [FRS_DW-1:0] port_b_data,
    output logic                   empty_flag_n,
    output logic                   full_flag_n,
    output logic                   almost_empty_n,
    output logic                   almost_full_n,
    output logic                   irq
);
    frs_width_type        width_now;
    frs_width_type        held_w_q;
    logic                 wr_req;
    logic                 mail_wr;
    logic                 rd_req;
    logic                 mail_rd;
    logic                 fifo_rd;
    logic                 need_new;
    logic                 fetch;
    logic                 step;
    logic                 last;
    logic                 held_q;
    logic                 be_q;
    logic                 be_use;
    logic [1:0]           idx_q;
    logic [1:0]           cur_idx;
    logic [1:0]           last_idx;
    logic [FRS_DW-1:0]    mailbox_q;
    logic [FRS_DW-1:0]    seen_word_q;
    logic [FRS_LVW-1:0]   ae_lvl_q;
    logic [FRS_LVW-1:0]   af_lvl_q;
    logic [FRS_LW-1:0]    level_q;
    logic                 empty_q;
    logic                 full_q;
    logic                 aempty_q;
    logic                 afull_q;
    logic [FRS_IRQ_W-1:0] ist_q;
    logic [FRS_IRQ_W-1:0] ist_d;
    logic [FRS_IRQ_W-1:0] imask_q;
    logic [FRS_IRQ_W-1:0] iev;
    logic [FRS_IRQ_W-1:0] w1c;
    logic                 irq_q;
    logic                 acc;
    logic                 fire;
    logic                 hit;
    logic [31:0]          rdata_d;
    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;

    frs_rd_if rd ();

    // ------------------------------------------------------------
    // port decode
    // ------------------------------------------------------------
    assign width_now = frs_width_type'({width_sel_hi, width_sel_lo});
    assign wr_req  = !port_a_select_n && port_a_direction
                     && !port_a_mailbox_sel;
    assign mail_wr = !port_a_select_n && port_a_direction
                     && port_a_mailbox_sel;
    assign rd_req  = !port_b_select_n && !port_b_direction;
    assign mail_rd = rd_req && (width_now == FRS_MAIL);
    assign fifo_rd = rd_req && !port_b_mailbox_sel
                     && (width_now != FRS_MAIL);

    // a new size drops the held pieces
    assign need_new = !held_q || (width_now != held_w_q);
    assign fetch    = fifo_rd && need_new && rd.avail;
    assign step     = fetch || (fifo_rd && !need_new);
    assign cur_idx  = fetch ? 2'h0 : idx_q;
    assign last     = step && (cur_idx == last_idx);
    assign be_use   = fetch ? big_endian_select : be_q;

    always_comb
    begin
        case (width_now)
            FRS_WORD: last_idx = 2'h1;
            FRS_BYTE: last_idx = 2'h3;
            default:  last_idx = 2'h0;
        endcase
    end

    assign rd.push  = wr_req && full_q;
    assign rd.wdata = port_a_data;
    assign rd.fetch = fetch;
    assign rd.rel_n = {1'b0, last} + {1'b0, fetch && held_q};

    // ------------------------------------------------------------
    // storage and output path
    // ------------------------------------------------------------
    frs_store u_store
    (
        .pclk    (pclk),
        .presetn (presetn),
        .rd      (rd)
    );

    frs_unpack u_unpack
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .rd        (rd),
        .step      (step),
        .swap      ({swap_sel_hi, swap_sel_lo}),
        .width     (width_now),
        .big_end   (be_use),
        .idx       (cur_idx),
        .load_mail (mail_rd),
        .mail_data (mailbox_q),
        .data      (port_b_data)
    );

    // ------------------------------------------------------------
    // piece sequencing
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            held_q   <= 1'b0;
            held_w_q <= FRS_LONG;
            be_q     <= 1'b0;
            idx_q    <= 2'h0;
        end
        else if (step)
        begin
            if (fetch)
            begin
                held_w_q <= width_now;
                be_q     <= big_endian_select;
            end
            held_q <= !last;
            idx_q  <= last ? 2'h0 : cur_idx + 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mailbox_q <= '0;
        else if (mail_wr)
            mailbox_q <= port_a_data;
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level_q  <= '0;
            empty_q  <= 1'b0;
            full_q   <= 1'b1;
            aempty_q <= 1'b0;
            afull_q  <= 1'b1;
        end
        else
        begin
            level_q  <= rd.level_nx;
            empty_q  <= (rd.level_nx != '0);
            full_q   <= (rd.level_nx != FRS_FULL_LVL);
            aempty_q <= (rd.level_nx > {1'b0, ae_lvl_q});
            afull_q  <= (rd.level_nx
                         < FRS_FULL_LVL - {1'b0, af_lvl_q});
        end
    end

    assign empty_flag_n   = empty_q;
    assign full_flag_n    = full_q;
    assign almost_empty_n = aempty_q;
    assign almost_full_n  = afull_q;

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    always_comb
    begin
        iev                = '0;
        iev[FRS_IRQ_EMPTY] = empty_q && (rd.level_nx == '0);
        iev[FRS_IRQ_FULL]  = full_q && (rd.level_nx == FRS_FULL_LVL);
        iev[FRS_IRQ_OVF]   = wr_req && !full_q;
        iev[FRS_IRQ_UNF]   = fifo_rd && need_new && !rd.avail;
        w1c = '0;
        if (fire && pwrite && (paddr == FRS_OFF_ISTAT))
            w1c = pwdata[FRS_IRQ_W-1:0];
        // a new event wins over its clear
        ist_d = (ist_q & ~w1c) | iev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ist_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            ist_q <= ist_d;
            irq_q <= |(ist_d & imask_q);
        end
    end

    assign irq = irq_q;

    // ------------------------------------------------------------
    // apb slave, one wait state
    // ------------------------------------------------------------
    assign acc  = psel && penable && !pready_q;
    assign fire = psel && penable && pready_q && !pslverr_q;

    always_comb
    begin
        hit     = 1'b1;
        rdata_d = '0;
        case (paddr)
            FRS_OFF_LEVEL:
            begin
                rdata_d[FRS_AE_POS +: FRS_LVW] = ae_lvl_q;
                rdata_d[FRS_AF_POS +: FRS_LVW] = af_lvl_q;
            end
            FRS_OFF_STAT:
            begin
                rdata_d[3:0] = {afull_q, aempty_q, full_q, empty_q};
                rdata_d[FRS_LVL_POS +: FRS_LW] = level_q;
            end
            FRS_OFF_ISTAT: rdata_d[FRS_IRQ_W-1:0] = ist_q;
            FRS_OFF_IMASK: rdata_d[FRS_IRQ_W-1:0] = imask_q;
            default:       hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
        else
        begin
            pready_q  <= acc;
            pslverr_q <= acc && !hit;
            if (acc)
                prdata_q <= rdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ae_lvl_q <= FRS_AE_RST;
            af_lvl_q <= FRS_AF_RST;
            imask_q  <= '0;
        end
        else if (fire && pwrite)
        begin
            if (paddr == FRS_OFF_LEVEL)
            begin
                ae_lvl_q <= pwdata[FRS_AE_POS +: FRS_LVW];
                af_lvl_q <= pwdata[FRS_AF_POS +: FRS_LVW];
            end
            if (paddr == FRS_OFF_IMASK)
                imask_q <= pwdata[FRS_IRQ_W-1:0];
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seen_word_q <= '0;
        else
            seen_word_q <= rd.word;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_swap_long;
        fetch && width_now == FRS_LONG && swap_sel_lo && !swap_sel_hi
        |=> port_b_data == {seen_word_q[8:0], seen_word_q[17:9],
                            seen_word_q[26:18], seen_word_q[35:27]};
    endproperty
    a_swap_long: assert property (p_swap_long)
        else $error("long read byte order wrong");

    property p_word_first;
        fetch && width_now == FRS_WORD && big_endian_select
        && !swap_sel_lo && !swap_sel_hi
        |=> port_b_data[35:18] == seen_word_q[35:18];
    endproperty
    a_word_first: assert property (p_word_first)
        else $error("first big endian word wrong");

    property p_word_hold;
        step && width_now == FRS_WORD && be_use
        |=> $stable(port_b_data[17:0]);
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("unused word half changed");

    property p_byte_hold;
        step && width_now == FRS_BYTE && !be_use
        |=> $stable(port_b_data[35:9]);
    endproperty
    a_byte_hold: assert property (p_byte_hold)
        else $error("unused byte lanes changed");

    property p_mail;
        mail_rd |=> port_b_data == $past(mailbox_q);
    endproperty
    a_mail: assert property (p_mail)
        else $error("mailbox not driven on port b");

    property p_empty_last;
        last && rd.level_nx == '0
        |=> !empty_flag_n ##1 (!empty_flag_n || $past(rd.push));
    endproperty
    a_empty_last: assert property (p_empty_last)
        else $error("empty not low after last piece");

    property p_empty_rise;
        !empty_flag_n && rd.push |=> empty_flag_n;
    endproperty
    a_empty_rise: assert property (p_empty_rise)
        else $error("empty not released after write");

    property p_full_rise;
        !full_flag_n && last |=> full_flag_n;
    endproperty
    a_full_rise: assert property (p_full_rise)
        else $error("full not released after read");

    property p_full_keep;
        !full_flag_n && step && !last && !(fetch && held_q) |=> !full_flag_n;
    endproperty
    a_full_keep: assert property (p_full_keep)
        else $error("full released before last piece");

    property p_aempty;
        !almost_empty_n && rd.push && rd.rel_n == 2'h0
        && level_q == {1'b0, ae_lvl_q} && !(fire && pwrite)
        |=> almost_empty_n;
    endproperty
    a_aempty: assert property (p_aempty)
        else $error("almost empty not released");

    property p_resize;
        fifo_rd && held_q && width_now != held_w_q && rd.avail |-> fetch;
    endproperty
    a_resize: assert property (p_resize)
        else $error("size change kept old long word");

    c_byte_run: cover property (fetch && width_now == FRS_BYTE
                                ##1 step [*3]);
    c_mail_mid: cover property (held_q && mail_rd ##1 step);
    c_full:     cover property (!full_flag_n ##[1:20] full_flag_n);
endmodule : frs_top

`default_nettype wire

/* File: hdl/frs_unpack.sv */
`timescale 1ns/1ps
`default_nettype none

module frs_unpack import frs_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    frs_rd_if.unpack               rd,
    input  wire logic              step,
    input  wire logic [1:0]        swap,
    input  wire frs_width_type     width,
    input  wire logic              big_end,
    input  wire logic [1:0]        idx,
    input  wire logic              load_mail,
    input  wire logic [FRS_DW-1:0] mail_data,
    output logic      [FRS_DW-1:0] data
);
    logic [FRS_DW-1:0] swapped;
    logic [FRS_DW-1:0] aux_q;
    logic [FRS_DW-1:0] src;
    logic [1:0]        key;
    logic [FRS_BW-1:0] lane_q [FRS_LANES];

    // output lane l takes input lane l xor key
    assign key = {swap[1] ^ swap[0], swap[0]};
    assign src = rd.fetch ? swapped : aux_q;
    assign data = {lane_q[3], lane_q[2], lane_q[1], lane_q[0]};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            aux_q <= '0;
        else if (rd.fetch)
            aux_q <= swapped;
    end

    for (genvar l = 0; l < FRS_LANES; l++)
    begin : g_lane
        localparam logic [1:0] LN = 2'(l);
        logic       hit;
        logic [1:0] pick;

        assign swapped[FRS_BW*l +: FRS_BW] =
            rd.word[FRS_BW*(LN ^ key) +: FRS_BW];

        always_comb
        begin
            hit  = 1'b0;
            pick = LN;
            case (width)
                FRS_LONG:
                    hit = 1'b1;
                FRS_WORD:
                begin
                    hit  = (LN[1] == big_end);
                    pick = {big_end ^ idx[0], LN[0]};
                end
                FRS_BYTE:
                begin
                    hit  = big_end ? (LN == 2'h3) : (LN == 2'h0);
                    pick = big_end ? ~idx : idx;
                end
                default:
                    hit = 1'b0;
            endcase
        end

        // lanes not hit keep their last data, except that a mailbox read loads all lanes
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                lane_q[l] <= '0;
            else if (load_mail)
                lane_q[l] <= mail_data[FRS_BW*l +: FRS_BW];
            else if (step && hit)
                lane_q[l] <= src[FRS_BW*pick +: FRS_BW];
        end
    end
endmodule : frs_unpack

`default_nettype wire

/* File: sim/frs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module frs_host_model import frs_pkg::*;
(
    input  wire logic              pclk,
    output logic                   port_a_select_n,
    output logic                   port_a_direction,
    output logic                   port_a_mailbox_sel,
    output logic      [FRS_DW-1:0] port_a_data,
    output logic                   port_b_select_n,
    output logic                   port_b_direction,
    output logic                   port_b_mailbox_sel,
    output logic                   width_sel_lo,
    output logic                   width_sel_hi,
    output logic                   swap_sel_lo,
    output logic                   swap_sel_hi,
    output logic                   big_endian_select
);
    // ------------------------------
    // idle levels at time zero
    // ------------------------------
    initial
    begin
        port_a_select_n    = 1'b1;
        port_a_direction   = 1'b0;
        port_a_mailbox_sel = 1'b0;
        port_a_data        = '0;
        port_b_select_n    = 1'b1;
        port_b_direction   = 1'b1;
        port_b_mailbox_sel = 1'b0;
        {width_sel_hi, width_sel_lo} = 2'h0;
        {swap_sel_hi, swap_sel_lo}   = 2'h0;
        big_endian_select  = 1'b0;
    end

    // ------------------------------
    // port transfers, one edge each
    // ------------------------------
    task automatic push(input logic [FRS_DW-1:0] d, input logic mb);
        port_a_select_n    <= 1'b0;
        port_a_direction   <= 1'b1;
        port_a_mailbox_sel <= mb;
        port_a_data        <= d;
        @(posedge pclk);
    endtask : push

    // released data bus shows no stale value
    task automatic a_idle();
        port_a_select_n <= 1'b1;
        port_a_data     <= ~port_a_data;
        @(posedge pclk);
    endtask : a_idle

    task automatic pull(input frs_width_type wd, input logic [1:0] sw,
                        input logic big);
        port_b_select_n    <= 1'b0;
        port_b_direction   <= 1'b0;
        port_b_mailbox_sel <= 1'b0;
        {width_sel_hi, width_sel_lo} <= wd;
        {swap_sel_hi, swap_sel_lo}   <= sw;
        big_endian_select  <= big;
        @(posedge pclk);
    endtask : pull

    task automatic b_idle();
        port_b_select_n <= 1'b1;
        @(posedge pclk);
    endtask : b_idle
endmodule : frs_host_model

`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            $display("wrong value %s expected %h seen %h", nm, ex, got); \
            fails++; \
        end \
    end

module tb_top import frs_pkg::*;
;
    logic              pclk = 1'b0, presetn = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]       pwdata = 32'h0, prdata;
    logic              pready, pslverr, irq;
    logic              port_a_select_n, port_a_direction, port_a_mailbox_sel;
    logic              port_b_select_n, port_b_direction, port_b_mailbox_sel;
    logic              width_sel_lo, width_sel_hi, swap_sel_lo, swap_sel_hi;
    logic              big_endian_select, empty_flag_n, full_flag_n;
    logic              almost_empty_n, almost_full_n;
    logic [FRS_DW-1:0] port_a_data, port_b_data;
    int                fails = 0;
    int                samples_checked = 0;

    always #4 pclk = ~pclk;

    frs_top DUT
    (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .port_a_select_n, .port_a_direction,
        .port_a_mailbox_sel, .port_a_data, .port_b_select_n,
        .port_b_direction, .port_b_mailbox_sel, .width_sel_lo, .width_sel_hi,
        .swap_sel_lo, .swap_sel_hi, .big_endian_select, .port_b_data,
        .empty_flag_n, .full_flag_n, .almost_empty_n, .almost_full_n, .irq
    );

    frs_host_model host
    (
        .pclk, .port_a_select_n, .port_a_direction, .port_a_mailbox_sel,
        .port_a_data, .port_b_select_n, .port_b_direction,
        .port_b_mailbox_sel, .width_sel_lo, .width_sel_hi, .swap_sel_lo,
        .swap_sel_hi, .big_endian_select
    );

    // ------------------------------
    // register access and checks
    // ------------------------------
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic chk_reg(input logic [11:0] a, input logic [31:0] ex,
                           input logic ee);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        `CHK("prdata", ex, rd)
        `CHK("pslverr", ee, er)
    endtask : chk_reg

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask : wr_reg

    function automatic logic [35:0] swp(input logic [35:0] w,
                                        input logic [1:0] c);
        case (c)
            2'h0:    return w;
            2'h1:    return {w[8:0], w[17:9], w[26:18], w[35:27]};
            2'h2:    return {w[17:9], w[8:0], w[35:27], w[26:18]};
            default: return {w[26:18], w[35:27], w[8:0], w[17:9]};
        endcase
    endfunction : swp

    // all pieces of one long word; later pieces get another swap code
    task automatic read_word(input logic [35:0] w, input frs_width_type wd,
                             input logic [1:0] c, input logic big,
                             input logic last);
        logic [35:0] s, m, ex;
        int          n, sz, p;
        s  = swp(w, c);
        n  = (wd == FRS_BYTE) ? 4 : ((wd == FRS_WORD) ? 2 : 1);
        sz = 36 / n;
        m  = (36'h1 << sz) - 36'h1;
        for (int k = 0; k < n; k++)
        begin
            ex = port_b_data;
            host.pull(wd, (k == 0) ? c : ~c, big);
            host.b_idle();
            p  = big ? (n - 1 - k) : k;
            if (big)
                ex = (ex & ~(m << (36 - sz)))
                     | (((s >> (p * sz)) & m) << (36 - sz));
            else
                ex = (ex & ~m) | ((s >> (p * sz)) & m);
            `CHK("port_b_data", ex, port_b_data)
            @(posedge pclk);
            `CHK("empty_flag_n", !(last && k == n - 1), empty_flag_n)
        end
    endtask : read_word

    task automatic conclude();
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // ------------------------------
    // test sequence
    // ------------------------------
    initial
    begin
        logic [35:0] w, w2;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk_reg(FRS_OFF_LEVEL, 32'h0000_0808, 1'b0);
        chk_reg(FRS_OFF_STAT, 32'h0000_000A, 1'b0);
        chk_reg(12'h010, 32'h0, 1'b1);
        wr_reg(FRS_OFF_ISTAT, 32'hF);
        host.pull(FRS_LONG, 2'h0, 1'b0);
        host.b_idle();
        chk_reg(FRS_OFF_ISTAT, 32'h8, 1'b0);
        `CHK("irq", 1'b0, irq)
        wr_reg(FRS_OFF_ISTAT, 32'hF);
        for (int i = 0; i < 24; i++)
        begin
            w = 36'h9A5C3E1F7 + 36'(i) * 36'h111111111;
            host.push(w, 1'b0);
            `CHK("empty_flag_n", 1'b0, empty_flag_n)
            host.a_idle();
            `CHK("empty_flag_n", 1'b1, empty_flag_n)
            read_word(w, frs_width_type'(2'(i / 8)), 2'(i % 4),
                      1'(i / 4 % 2), 1'b1);
        end
        w  = 36'h8C3A5F0E1;
        w2 = 36'h1E2D3C4B5;
        host.push(w, 1'b1);
        host.push(w2, 1'b0);
        host.a_idle();
        host.pull(FRS_WORD, 2'h0, 1'b1);
        host.b_idle();
        `CHK("port_b_data", w2[35:18], port_b_data[35:18])
        host.pull(FRS_MAIL, 2'h1, 1'b1);
        host.b_idle();
        `CHK("port_b_data", w, port_b_data)
        host.pull(FRS_WORD, 2'h2, 1'b1);
        host.b_idle();
        `CHK("port_b_data", w2[17:0], port_b_data[35:18])
        host.push(w, 1'b0);
        host.push(w2, 1'b0);
        host.a_idle();
        host.pull(FRS_BYTE, 2'h0, 1'b1);
        host.b_idle();
        `CHK("port_b_data", w[35:27], port_b_data[35:27])
        read_word(w2, FRS_LONG, 2'h0, 1'b0, 1'b1);
        for (int i = 0; i < 8; i++) host.push(36'(i), 1'b0);
        host.a_idle();
        @(posedge pclk);
        `CHK("almost_empty_n", 1'b0, almost_empty_n)
        host.push(36'h8, 1'b0);
        `CHK("almost_empty_n", 1'b0, almost_empty_n)
        host.a_idle();
        `CHK("almost_empty_n", 1'b1, almost_empty_n)
        for (int i = 9; i < 64; i++) host.push(36'(i), 1'b0);
        `CHK("full_flag_n", 1'b1, full_flag_n)
        host.a_idle();
        `CHK("full_flag_n", 1'b0, full_flag_n)
        host.push(36'h0, 1'b0);
        host.a_idle();
        chk_reg(FRS_OFF_STAT, 32'h0000_4005, 1'b0);
        chk_reg(FRS_OFF_ISTAT, 32'h7, 1'b0);
        `CHK("irq", 1'b0, irq)
        wr_reg(FRS_OFF_IMASK, 32'h4);
        @(posedge pclk);
        `CHK("irq", 1'b1, irq)
        wr_reg(FRS_OFF_ISTAT, 32'h4);
        chk_reg(FRS_OFF_ISTAT, 32'h3, 1'b0);
        `CHK("irq", 1'b0, irq)
        host.pull(FRS_WORD, 2'h0, 1'b1);
        host.b_idle();
        @(posedge pclk);
        `CHK("full_flag_n", 1'b0, full_flag_n)
        host.pull(FRS_WORD, 2'h0, 1'b1);
        `CHK("full_flag_n", 1'b0, full_flag_n)
        host.b_idle();
        `CHK("full_flag_n", 1'b1, full_flag_n)
        for (int i = 0; i < 8; i++) host.pull(FRS_LONG, 2'h0, 1'b0);
        `CHK("almost_full_n", 1'b0, almost_full_n)
        host.b_idle();
        `CHK("almost_full_n", 1'b1, almost_full_n)
        conclude();
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        fails++;
        conclude();
    end
endmodule : tb_top

`undef CHK
`default_nettype wire
